// [design/tdmftc_top.sv]
// Frame timing and mode control for a TDM serial/parallel converter, AHB-Lite slave.
// Assumes the 16 MHz and 4 MHz pins are much slower than twice clk_sys_i is fast enough
// to resolve each edge, and that a single master drives the bus.
//
// The AHB-Lite register port and the placing of the registers are this design's own decisions.
module tdmftc_top
   import tdmftc_pkg::*;
(
   input  wire logic            clk_sys_i,
   input  wire logic            rst_b_i,
   input  wire tdmftc_ahb_req_t ahb_i,
   output tdmftc_ahb_rsp_t      ahb_o,
   input  wire logic            clk_16m_in_i,
   input  wire logic            clk_4m_in_i,
   input  wire logic            frame_pulse_in_i,
   output logic                 frame_pulse_out_n_o,
   output logic                 clk_2m_out_o,
   output logic                 clk_4m_out_o,
   output logic                 connect_mem_frame_pulse_n_o,
   output logic                 data_mem_frame_pulse_o,
   output logic                 data_mem_frame_pulse_n_o,
   output logic                 parallel_oe_o,
   output logic [31:0]          serial_oe_o,
   output logic                 serial_bit_strobe_o
);

   tdmftc_state_t st_q;
   tdmftc_state_t st_d;

   logic [SY_W-1:0] sy_filt;
   logic [SY_W-1:0] sy_rise;
   logic [SY_W-1:0] sy_fall;
   logic            c16_rise;
   logic            c4_fall;
   logic            bnd;
   logic [1:0]      arm_eff;
   logic            acc;
   logic [10:0]     cfp_th;
   logic [10:0]     bit_mask;
   logic [10:0]     ch_mask;
   logic [31:0]     rd_val;

   // All three pins share one synchroniser bundle so their edges stay in step.
   tdmftc_sync #(
      .WIDTH (SY_W)
   ) u_sync (
      .clk_sys_i (clk_sys_i),
      .rst_b_i   (rst_b_i),
      .pin_i     ({frame_pulse_in_i, clk_4m_in_i, clk_16m_in_i}),
      .filt_o    (sy_filt),
      .rise_o    (sy_rise),
      .fall_o    (sy_fall)
   );

   // Edge events seen in the system domain.
   assign c16_rise = sy_rise[SY_C16];
   assign c4_fall  = sy_fall[SY_C4];
   // Boundary: this 4 MHz fall samples the frame input low, the previous one high.
   assign bnd      = c4_fall & ~sy_filt[SY_FP] & st_q.fp_samp; // R5 R12
   assign acc      = ahb_i.hsel & ahb_i.htrans[1] & ahb_i.hready;

   // Delay-dependent thresholds and rate-dependent masks.
   assign cfp_th   = st_q.ctrl.clock_delay_select ? CFP_TH_D1 : CFP_TH_D0; // R11 R4
   assign bit_mask = st_q.ctrl.rate ? BIT_MASK_4M : BIT_MASK_2M; // R9
   assign ch_mask  = st_q.ctrl.rate ? CH_MASK_4M : CH_MASK_2M; // R9

   // A new boundary overrides any pending reset; delay select picks how far off it is.
   always_comb begin
      arm_eff = st_q.arm;
      if (bnd) begin
         arm_eff = st_q.ctrl.clock_delay_select ? ARM_LATE : ARM_NOW; // R1 R2
      end
   end

   // Register read mux; unmapped addresses read as zero.
   always_comb begin
      rd_val = 32'h00000000;
      case (st_q.addr)
         ADDR_CTRL: begin
            rd_val = {28'h0000000, st_q.ctrl};
         end
         ADDR_STATUS: begin
            rd_val                = {21'h000000, st_q.cnt};
            rd_val[STAT_LOCK_BIT] = (st_q.fsm == ST_RUN);
            rd_val[STAT_SEEN_BIT] = st_q.seen;
         end
         default: begin
            rd_val = 32'h00000000;
         end
      endcase
   end

   // Next state of the whole block.
   always_comb begin
      st_d        = st_q;
      st_d.strobe = 1'b0;

      // Frame input sample is taken only on the 4 MHz falling edge.
      if (c4_fall) begin
         st_d.fp_samp = sy_filt[SY_FP]; // R5
      end

      // Master counter: one count per 16 MHz edge, reset placed by the arm state.
      st_d.arm = arm_eff;
      if (c16_rise) begin
         if (arm_eff == ARM_NOW) begin
            st_d.cnt = CNT_ZERO; // R1 R2
            st_d.arm = ARM_IDLE;
         end else if (arm_eff == ARM_LATE) begin
            st_d.cnt = st_q.cnt + CNT_ONE; // R2
            st_d.arm = ARM_NOW;
         end else begin
            st_d.cnt = st_q.cnt + CNT_ONE; // R16
         end
      end

      // Lock tracking; frame pulses and serial drive stay idle until the first boundary is found, while the clocks and strobe run.
      case (st_q.fsm)
         ST_HUNT: begin
            if (bnd) begin
               st_d.fsm = ST_RUN;
            end
         end
         ST_RUN: begin
            st_d.fsm = ST_RUN;
         end
         default: begin
            st_d.fsm = ST_HUNT;
         end
      endcase

      // Every edge derives from the new count, so delay select shifts them all.
      if (c16_rise) begin
         st_d.c4 = ~st_d.cnt[1]; // R14 R16 R4
         st_d.c2 = ~st_d.cnt[2]; // R16 R4
         st_d.strobe = (st_d.cnt & bit_mask) == CNT_ZERO; // R3 R9
         if (st_q.fsm == ST_RUN) begin
            // A pulse may only begin at its first count, so a lock inside it leaves no runt.
            st_d.fp_out_n = ~((st_d.cnt >= FP_LOW_START) ||
                              ((st_d.cnt < FP_LOW_END) && !st_q.fp_out_n)); // R14
            st_d.cfp_n    = ~((st_d.cnt >= cfp_th) && (st_d.cnt < cfp_th + CFP_LOW_LEN)); // R11
            if (st_d.cnt == DFP_TOGGLE_CNT && st_q.cnt != DFP_TOGGLE_CNT) begin
               st_d.dfp = ~st_q.dfp; // R13
            end
            // ser_en follows oe_n only at a channel start, so a drive enable change cuts no bit short.
            if ((st_d.cnt & ch_mask) == CNT_ZERO) begin
               st_d.ser_en = ~st_q.ctrl.oe_n; // R7 R3
            end
         end else begin
            st_d.fp_out_n = 1'b1;
            st_d.cfp_n    = 1'b1;
            st_d.ser_en   = 1'b0;
         end
      end

      // Bus data phase: a write lands one cycle after its address phase.
      if (st_q.wr_pend) begin
         case (st_q.addr)
            ADDR_CTRL: begin
               st_d.ctrl = tdmftc_ctrl_t'(ahb_i.hwdata[3:0]);
            end
            ADDR_STATUS: begin
               if (ahb_i.hwdata[STAT_SEEN_BIT]) begin
                  st_d.seen = 1'b0;
               end
            end
            default: begin
               st_d.seen = st_q.seen;
            end
         endcase
      end
      // Set wins over a clear in the same cycle, so no boundary report is lost.
      if (bnd) begin
         st_d.seen = 1'b1;
      end

      // A read waits one cycle so it sees a write from the transfer just before.
      if (st_q.rd_wait) begin
         st_d.hrdata  = rd_val;
         st_d.rd_wait = 1'b0;
      end
      st_d.wr_pend = 1'b0;
      if (acc) begin
         st_d.addr    = ahb_i.haddr[7:0];
         st_d.wr_pend = ahb_i.hwrite;
         st_d.rd_wait = ~ahb_i.hwrite;
      end
   end

   // Single state register for the block.
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_q <= STATE_RST;
      end else begin
         st_q <= st_d;
      end
   end

   // Bus response: always OKAY, one wait state on reads only.
   assign ahb_o.hreadyout = ~st_q.rd_wait;
   assign ahb_o.hresp     = 1'b0;
   assign ahb_o.hrdata    = st_q.hrdata;

   // Pin outputs straight from state.
   assign frame_pulse_out_n_o         = st_q.fp_out_n;
   assign clk_2m_out_o                = st_q.c2;
   assign clk_4m_out_o                = st_q.c4;
   assign connect_mem_frame_pulse_n_o = st_q.cfp_n;
   assign data_mem_frame_pulse_o      = st_q.dfp;
   assign data_mem_frame_pulse_n_o    = ~st_q.dfp;
   assign serial_bit_strobe_o         = st_q.strobe;

   // Parallel release is immediate; serial drive also needs the mode to allow it, and the rate picks which streams are driven.
   assign parallel_oe_o = ~st_q.ctrl.oe_n & ~st_q.ctrl.dir; // R7 R8 R10
   assign serial_oe_o   = (st_q.ser_en & st_q.ctrl.dir) ?
                          (st_q.ctrl.rate ? STREAM_LOWER : STREAM_ALL) : 32'h00000000; // R10 R15

   // Checks on the timing relations; all in the system clock domain.
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_b_i);

   a_reset_at_bnd: assert property ( // R1
      (bnd && !st_q.ctrl.clock_delay_select && c16_rise) |=> (st_q.cnt == CNT_ZERO))
      else $error("counter not cleared at boundary with delay low");

   a_reset_late_arm: assert property ( // R2
      (bnd && st_q.ctrl.clock_delay_select && c16_rise) |=>
         (st_q.arm == ARM_NOW && st_q.cnt == $past(st_q.cnt) + CNT_ONE))
      else $error("late reset not armed after boundary");

   a_reset_late_fire: assert property ( // R2
      (st_q.arm == ARM_NOW && c16_rise && !bnd) |=> (st_q.cnt == CNT_ZERO && st_q.arm == ARM_IDLE))
      else $error("pending counter reset did not fire");

   a_bnd_on_fall: assert property ( // R5 R12
      bnd |=> (st_q.seen && st_q.fsm == ST_RUN))
      else $error("boundary not recorded");

   a_par_oe_gate: assert property ( // R7 R8
      st_q.ctrl.oe_n |-> !parallel_oe_o)
      else $error("parallel outputs driven while drive enable high");

   a_ser_dir_only: assert property ( // R10
      (serial_oe_o != 32'h00000000) |-> (st_q.ctrl.dir && !parallel_oe_o))
      else $error("serial outputs driven outside parallel-to-serial mode");

   a_upper_quiet: assert property ( // R15
      st_q.ctrl.rate |-> (serial_oe_o[31:16] == 16'h0000))
      else $error("upper streams driven at the high rate");

   a_strobe_rate: assert property ( // R9
      serial_bit_strobe_o |->
         ((st_q.cnt & ($past(st_q.ctrl.rate) ? BIT_MASK_4M : BIT_MASK_2M)) == CNT_ZERO))
      else $error("bit strobe off the rate grid");

   a_cfp_fall_pos: assert property ( // R11
      $fell(connect_mem_frame_pulse_n_o) |->
         (st_q.cnt == ($past(st_q.ctrl.clock_delay_select) ? CFP_TH_D1 : CFP_TH_D0)))
      else $error("connect memory pulse fell at wrong count");

   a_dfp_toggle_pos: assert property ( // R13
      $changed(data_mem_frame_pulse_o) |-> (st_q.cnt == DFP_TOGGLE_CNT))
      else $error("data memory pulse changed at wrong count");

   a_fp_out_pos: assert property ( // R14
      $fell(frame_pulse_out_n_o) |-> (st_q.cnt == FP_LOW_START && !clk_4m_out_o))
      else $error("frame pulse output misplaced");

   a_cnt_wrap: assert property ( // R16
      (c16_rise && st_q.cnt == CNT_LAST && arm_eff == ARM_IDLE) |=> (st_q.cnt == CNT_ZERO))
      else $error("master counter did not wrap after 2048 counts");

   a_read_wait: assert property (
      (acc && !ahb_i.hwrite) |=> (!ahb_o.hreadyout ##1 ahb_o.hreadyout))
      else $error("read wait state wrong");

   // The frame sample may only move on a 4 MHz fall, or a slow pin would jitter the boundary.
   a_samp_hold: assert property ( // R5
      !c4_fall |=> $stable(st_q.fp_samp))
      else $error("frame sample moved off a 4 MHz fall");

   a_samp_take: assert property ( // R5
      c4_fall |=> (st_q.fp_samp == $past(sy_filt[SY_FP])))
      else $error("frame sample not taken on a 4 MHz fall");

   a_cnt_hold: assert property ( // R16
      !c16_rise |=> $stable(st_q.cnt))
      else $error("master counter moved without a 16 MHz edge");

   a_cnt_step: assert property ( // R16 R2
      (c16_rise && arm_eff != ARM_NOW) |=> (st_q.cnt == $past(st_q.cnt) + CNT_ONE))
      else $error("master counter skipped a count");

   a_cfp_width: assert property ( // R11
      $rose(connect_mem_frame_pulse_n_o) |->
         (st_q.cnt == $past(cfp_th) + CFP_LOW_LEN))
      else $error("connect memory pulse width wrong");

   a_ser_chan: assert property ( // R7 R3
      $changed(st_q.ser_en) |-> ((st_q.cnt & $past(ch_mask)) == CNT_ZERO))
      else $error("serial drive changed inside a channel");

   a_hunt_idle: assert property ( // R14
      (st_q.fsm == ST_HUNT) |->
         (frame_pulse_out_n_o && connect_mem_frame_pulse_n_o && serial_oe_o == 32'h00000000))
      else $error("timing outputs active before lock");

   a_ctrl_write: assert property ( // R7
      (st_q.wr_pend && st_q.addr == ADDR_CTRL) |=> (st_q.ctrl == $past(ahb_i.hwdata[3:0])))
      else $error("control write did not land");

   a_seen_clear: assert property ( // R12
      (st_q.wr_pend && st_q.addr == ADDR_STATUS && ahb_i.hwdata[STAT_SEEN_BIT] && !bnd) |=>
         !st_q.seen)
      else $error("boundary flag not cleared");

   a_read_data: assert property (
      st_q.rd_wait |=> (ahb_o.hrdata == $past(rd_val)))
      else $error("read data not loaded");

   // Main scenarios.
   c_lock: cover property (st_q.fsm == ST_HUNT && bnd);
   c_late_reset: cover property (st_q.arm == ARM_LATE && c16_rise);
   c_cfp_pulse: cover property ($fell(connect_mem_frame_pulse_n_o));
   c_dfp_toggle: cover property ($changed(data_mem_frame_pulse_o));
   c_status_read: cover property (acc && !ahb_i.hwrite && ahb_i.haddr[7:0] == ADDR_STATUS);

endmodule // tdmftc_top

// [design/tdmftc_pkg.sv]
// Constants, register map and carrier types of the TDM frame timing control block.
// Assumes one 25 MHz system clock; the 16 MHz, 4 MHz and frame pins arrive asynchronously.
// What this block and its timing source must do
// R1 - With delay select low, master counter resets exactly at the frame boundary.
// R2 - With delay select high, master counter resets one 16 MHz period after boundary.
// R3 - Delay select high delays all serial and parallel data timing by one 16 MHz period.
// R4 - Delay select shifts data, output enable and all frame pulse and clock phases.
// R5 - The frame pulse input is sampled on the falling edge of the 4 MHz clock.
// R6 - The timing source supplies a 4 MHz clock phase locked to its 16 MHz clock.
// R7 - Output data bus is driven while drive enable is low, released while high.
// R8 - Serial-to-parallel mode releases parallel outputs at once when drive enable goes high.
// R9 - Serial streams run at 2.048 Mbit/s with rate select low, 4.096 with it high.
// R10 - Direction low converts serial to parallel, high converts parallel to serial.
// R11 - Connect memory pulse falls 71 (delay 0) or 68 (delay 1) cycles before boundary.
// R12 - Frame boundary is the first 4 MHz falling edge after the frame input falls.
// R13 - Data memory pulse toggles 64 (delay 0) or 65 (delay 1) cycles after boundary.
// R14 - Frame pulse output marks each boundary, aligned with the 4 MHz clock output.
// R15 - Upper sixteen serial streams stay inactive when the higher rate is selected.
// R16 - Master counter counts 2048 cycles per frame and drives all output edges; parallel_oe_o and serial_oe_o gating follow the control register.
package tdmftc_pkg;

   // Register byte addresses, decoded on the low address byte.
   localparam logic [7:0]  ADDR_CTRL       = 8'h00;
   localparam logic [7:0]  ADDR_STATUS     = 8'h04;
   // Status field positions.
   localparam int          STAT_LOCK_BIT   = 16;
   localparam int          STAT_SEEN_BIT   = 17;

   // Master counter geometry.
   localparam int          CNT_W           = 11;
   localparam int          FRAME_CYCLES    = 2048;
   localparam int          CFP_BEFORE_D0   = 71;
   localparam int          CFP_BEFORE_D1   = 68;
   // With delay high the boundary sits at the last count before the late reset.
   localparam logic [10:0] CFP_TH_D0       = 11'(FRAME_CYCLES - CFP_BEFORE_D0);
   localparam logic [10:0] CFP_TH_D1       = 11'(FRAME_CYCLES - 1 - CFP_BEFORE_D1);
   localparam logic [10:0] CFP_LOW_LEN     = 11'h004;
   // Same count for both settings: the late reset itself adds the extra cycle.
   localparam logic [10:0] DFP_TOGGLE_CNT  = 11'h040;
   localparam logic [10:0] FP_LOW_START    = 11'h7fe;
   localparam logic [10:0] FP_LOW_END      = 11'h002;
   localparam logic [10:0] CNT_LAST        = 11'h7ff;
   localparam logic [10:0] CNT_ZERO        = 11'h000;
   localparam logic [10:0] CNT_ONE         = 11'h001;
   // Cycle masks for bit and channel starts at the two serial rates.
   localparam logic [10:0] BIT_MASK_2M     = 11'h007;
   localparam logic [10:0] BIT_MASK_4M     = 11'h003;
   localparam logic [10:0] CH_MASK_2M      = 11'h03f;
   localparam logic [10:0] CH_MASK_4M      = 11'h01f;
   localparam logic [31:0] STREAM_ALL      = 32'hffffffff;
   localparam logic [31:0] STREAM_LOWER    = 32'h0000ffff;

   // Pending counter reset: none, at next 16 MHz edge, or one edge later.
   localparam logic [1:0]  ARM_IDLE        = 2'h0;
   localparam logic [1:0]  ARM_NOW         = 2'h1;
   localparam logic [1:0]  ARM_LATE        = 2'h2;
   // Indices into the synchroniser bundle.
   localparam int          SY_C16          = 0;
   localparam int          SY_C4           = 1;
   localparam int          SY_FP           = 2;
   localparam int          SY_W            = 3;

   typedef enum logic [1:0] {
      ST_HUNT = 2'b01,
      ST_RUN  = 2'b10
   } tdmftc_fsm_t;

   typedef struct packed {
      logic oe_n;
      logic dir;
      logic rate;
      logic clock_delay_select;
   } tdmftc_ctrl_t;

   localparam tdmftc_ctrl_t CTRL_RST = '{oe_n: 1'b1, dir: 1'b0, rate: 1'b0, clock_delay_select: 1'b0};

   typedef struct packed {
      logic        hsel;
      logic [31:0] haddr;
      logic [1:0]  htrans;
      logic        hwrite;
      logic [2:0]  hsize;
      logic [31:0] hwdata;
      logic        hready;
   } tdmftc_ahb_req_t;

   typedef struct packed {
      logic        hreadyout;
      logic        hresp;
      logic [31:0] hrdata;
   } tdmftc_ahb_rsp_t;

   typedef struct packed {
      tdmftc_fsm_t  fsm;
      tdmftc_ctrl_t ctrl;
      logic         seen;
      logic         wr_pend;
      logic         rd_wait;
      logic [7:0]   addr;
      logic [31:0]  hrdata;
      logic         fp_samp;
      logic [1:0]   arm;
      logic [10:0]  cnt;
      logic         fp_out_n;
      logic         c2;
      logic         c4;
      logic         cfp_n;
      logic         dfp;
      logic         ser_en;
      logic         strobe;
   } tdmftc_state_t;

   localparam tdmftc_state_t STATE_RST = '{
      fsm: ST_HUNT, ctrl: CTRL_RST, seen: 1'b0, wr_pend: 1'b0, rd_wait: 1'b0,
      addr: 8'h00, hrdata: 32'h00000000, fp_samp: 1'b1, arm: ARM_IDLE, cnt: CNT_ZERO,
      fp_out_n: 1'b1, c2: 1'b0, c4: 1'b0, cfp_n: 1'b1, dfp: 1'b0, ser_en: 1'b0,
      strobe: 1'b0};

endpackage : tdmftc_pkg

// [design/tdmftc_sync.sv]
// Three-stage pin synchroniser with agreement filter and edge pulses.
// Assumes inputs are asynchronous to clk_sys_i; outputs are registered.
module tdmftc_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk_sys_i,
   input  wire logic             rst_b_i,
   input  wire logic [WIDTH-1:0] pin_i,
   output logic      [WIDTH-1:0] filt_o,
   output logic      [WIDTH-1:0] rise_o,
   output logic      [WIDTH-1:0] fall_o
);

   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] filt;
      logic [WIDTH-1:0] rise;
      logic [WIDTH-1:0] fall;
   } tdmftc_sync_t;

   tdmftc_sync_t st_q;
   tdmftc_sync_t st_d;
   logic [WIDTH-1:0] agree;

   // The first stage feeds only the second; the filter looks at stages two and three.
   always_comb begin
      st_d      = st_q;
      agree     = ~(st_q.s2 ^ st_q.s3);
      st_d.s1   = pin_i;
      st_d.s2   = st_q.s1;
      st_d.s3   = st_q.s2;
      st_d.filt = (agree & st_q.s3) | (~agree & st_q.filt);
      st_d.rise = st_d.filt & ~st_q.filt;
      st_d.fall = ~st_d.filt & st_q.filt;
   end

   // State register; all stages clear under reset.
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign filt_o = st_q.filt;
   assign rise_o = st_q.rise;
   assign fall_o = st_q.fall;

endmodule // tdmftc_sync

// [dv/tdmftc_timing_src.sv]
// Behavioural system timing source: 16 MHz clock, phase locked 4 MHz clock, frame pulse.
// Assumes the bench scales the clock period so the 25 MHz sampler can resolve every edge.
module tdmftc_timing_src #(
   parameter real HALF_NS = 167.0
) (
   output logic        c16_o,
   output logic        c4_o,
   output logic        fp_n_o,
   output logic [10:0] cnt_o
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [10:0] nxt;

   // Start just short of a boundary so the first frame arrives quickly.
   initial begin
      c16_o  = 1'b0;
      c4_o   = 1'b1;
      fp_n_o = 1'b1;
      cnt_o  = 11'h7f0;
   end

   // The 16 MHz clock runs free; non-blocking, so a coincident sampler edge sees old pins.
   always #(HALF_NS) c16_o <= ~c16_o;

   // The 4 MHz clock and frame pulse change only on 16 MHz rises, so they stay locked.
   always @(posedge c16_o) begin
      nxt = cnt_o + 11'h001;
      cnt_o <= nxt;
      c4_o <= nxt[1];
      // Frame input falls two counts before the boundary fall of the 4 MHz clock.
      fp_n_o <= !(nxt >= 11'h7fe || nxt < 11'h002);
   end
endmodule // tdmftc_timing_src

// [dv/testbench.sv]
// Self-checking bench for the frame timing control block.
// Assumes the timing source model in this folder and the design package.
module testbench
   import tdmftc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic            clk_sys = 1'b0;
   logic            rst_b = 1'b0;
   tdmftc_ahb_req_t mreq;
   tdmftc_ahb_req_t req_w;
   tdmftc_ahb_rsp_t rsp;
   logic            c16, c4, fpi, fp_out_n, c2o, c4o, cfp_n, dfp, dfp_n, par_oe, strobe;
   logic [10:0]     pcnt;
   logic [31:0]     ser_oe;
   logic [31:0]     rd;
   int              miscompares = 0;
   int              total_checks = 0;

   // The clock toggles every half period of 20 ns.
   always #20 clk_sys = ~clk_sys;

   // The bus hready is the one slave's hreadyout.
   always_comb begin
      req_w = mreq;
      req_w.hready = rsp.hreadyout;
   end

   tdmftc_timing_src #(.HALF_NS(167.0)) SRC (.c16_o(c16), .c4_o(c4), .fp_n_o(fpi), .cnt_o(pcnt));

   tdmftc_top DUT (
      .clk_sys_i(clk_sys), .rst_b_i(rst_b), .ahb_i(req_w), .ahb_o(rsp),
      .clk_16m_in_i(c16), .clk_4m_in_i(c4), .frame_pulse_in_i(fpi),
      .frame_pulse_out_n_o(fp_out_n), .clk_2m_out_o(c2o), .clk_4m_out_o(c4o),
      .connect_mem_frame_pulse_n_o(cfp_n), .data_mem_frame_pulse_o(dfp),
      .data_mem_frame_pulse_n_o(dfp_n), .parallel_oe_o(par_oe), .serial_oe_o(ser_oe),
      .serial_bit_strobe_o(strobe));

   task automatic end_sim();
      $display("Checks %0d, mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // Waits for a rising edge at which hready is sampled high.
   task automatic wait_rdy();
      int n;
      n = 0;
      @(posedge clk_sys);
      while (rsp.hreadyout !== 1'b1 && n < 50) begin
         @(posedge clk_sys);
         n++;
      end
      // A slave that never answers is a failure, not a silent skip.
      if (rsp.hreadyout !== 1'b1) begin
         miscompares++;
         $display("MISMATCH at %0t got %h expected %h", $time, rsp.hreadyout, 1'b1);
      end
   endtask

   // One single word transfer; called just after a rising edge.
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      mreq.hsel <= 1'b1;
      mreq.haddr <= a;
      mreq.htrans <= 2'b10;
      mreq.hwrite <= wr;
      mreq.hsize <= 3'b010;
      wait_rdy();
      mreq.hsel <= 1'b0;
      mreq.htrans <= 2'b00;
      mreq.hwdata <= wd;
      wait_rdy();
      rd = rsp.hrdata;
   endtask

   // Writes a register and lets the edge's updates land before anything is looked at.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      ahb(1'b1, 32'(a), d);
      #1;
   endtask

   task automatic rdreg(input logic [7:0] a, input logic [31:0] exp);
      ahb(1'b0, 32'(a), 32'h00000000);
      chk(rd, exp);
      chk(32'(rsp.hresp), 32'h00000000);
   endtask

   // Skips to the next fall of the frame pulse output.
   task automatic wait_fp();
      int n;
      n = 0;
      while (!(fp_out_n === 1'b1) && n < 20000) begin @(posedge clk_sys); n++; end
      while (!(fp_out_n === 1'b0) && n < 20000) begin @(posedge clk_sys); n++; end
   endtask

   // One frame: source count at each pulse's leading edge, measured from the source's own boundary.
   task automatic measure(input int e_cfp, input int e_dfp, input int e_fp);
      logic pc, pd, pf;
      int   n, seen;
      pc = cfp_n;
      pd = dfp;
      pf = fp_out_n;
      seen = 0;
      n = 0;
      while (seen != 7 && n < 20000) begin
         @(posedge clk_sys);
         n++;
         if (pc === 1'b1 && cfp_n === 1'b0) begin
            chk(32'(pcnt), 32'(e_cfp));
            seen |= 1;
         end
         if (pd !== dfp) begin
            chk(32'(pcnt), 32'(e_dfp));
            chk(32'(dfp_n), 32'(!dfp));
            seen |= 2;
         end
         if (pf === 1'b1 && fp_out_n === 1'b0) begin
            chk(32'(pcnt), 32'(e_fp));
            chk(32'({c2o, c4o}), 32'h00000000);
            seen |= 4;
         end
         pc = cfp_n;
         pd = dfp;
         pf = fp_out_n;
      end
      chk(32'(seen), 32'h00000007);
   endtask

   task automatic wait_ser(input logic [31:0] v);
      int n;
      n = 0;
      while (ser_oe !== v && n < 1000) begin @(posedge clk_sys); n++; end
   endtask

   // Source counts between two bit strobes give the serial bit period.
   task automatic strobe_gap(input logic [10:0] exp);
      logic [10:0] a;
      int          n;
      n = 0;
      @(posedge clk_sys);
      while (strobe !== 1'b1 && n < 100) begin @(posedge clk_sys); n++; end
      a = pcnt;
      @(posedge clk_sys);
      while (strobe !== 1'b1 && n < 200) begin @(posedge clk_sys); n++; end
      chk(32'(11'(pcnt - a)), 32'(exp));
   endtask

   task automatic test_reset();
      chk(32'({fp_out_n, cfp_n, dfp, par_oe}), 32'h0000000c);
      chk(ser_oe, 32'h00000000);
      rdreg(ADDR_CTRL, 32'h00000008);
      rdreg(8'h10, 32'h00000000);
      $display("test reset done");
   endtask

   task automatic test_parallel();
      wr(ADDR_CTRL, 32'h00000000);
      chk(32'(par_oe), 32'h00000001);
      chk(ser_oe, 32'h00000000);
      wr(ADDR_CTRL, 32'h00000008);
      chk(32'(par_oe), 32'h00000000);
      rdreg(ADDR_CTRL, 32'h00000008);
      $display("test parallel done");
   endtask

   task automatic test_serial();
      wr(ADDR_CTRL, 32'h00000004);
      wait_ser(STREAM_ALL);
      chk(ser_oe, STREAM_ALL);
      chk(32'(par_oe), 32'h00000000);
      strobe_gap(11'h008);
      wr(ADDR_CTRL, 32'h00000006);
      wait_ser(STREAM_LOWER);
      chk(ser_oe, STREAM_LOWER);
      strobe_gap(11'h004);
      wr(ADDR_CTRL, 32'h0000000e);
      wait_ser(32'h00000000);
      chk(ser_oe, 32'h00000000);
      $display("test serial done");
   endtask

   // Reset, then the scenarios in turn.
   initial begin
      mreq = '0;
      repeat (12) @(posedge clk_sys);
      rst_b <= 1'b1;
      @(posedge clk_sys);
      test_reset();
      wait_fp();
      measure(1977, 64, 2046);
      $display("test delay low done");
      ahb(1'b0, 32'(ADDR_STATUS), 32'h00000000);
      chk(32'(rd[STAT_LOCK_BIT]), 32'h00000001);
      chk(32'(rd[STAT_SEEN_BIT]), 32'h00000001);
      wr(ADDR_STATUS, 32'h00020000);
      ahb(1'b0, 32'(ADDR_STATUS), 32'h00000000);
      chk(32'(rd[STAT_SEEN_BIT]), 32'h00000000);
      test_parallel();
      test_serial();
      wr(ADDR_CTRL, 32'h00000009);
      wait_fp();
      measure(1980, 65, 2047);
      $display("test delay high done");
      end_sim();
   end

   // Four frames of about 17100 cycles each, plus short tests and margin.
   initial begin
      repeat (95000) @(posedge clk_sys);
      miscompares++;
      $display("Watchdog expired");
      end_sim();
   end
endmodule // testbench
